// File: rtl/typec_port_mux_ctrl.sv
// Control logic of the two-stage Type-C port data multiplexer.
// Assumes orientation, comparator and endpoint inputs are synchronous to clk.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "typec_mux_regs.svh"

module typec_port_mux_ctrl (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Register port
  input  wire logic [`MUX_ADDR_W-1:0]    reg_addr,
  input  wire logic [`MUX_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`MUX_DATA_W-1:0]    reg_rdata,
  output logic                           irq,
  // Orientation from the plug detector
  input  wire logic                      orient_valid,
  input  wire logic                      orient_flip,
  // First-stage selections and second-stage switches
  output typec_mux_pkg::src_t            dst_top_src,
  output typec_mux_pkg::src_t            dst_bottom_src,
  output typec_mux_pkg::src_t            dst_side_src,
  output logic      [`PORT_PINS-1:0]     sw2_close,
  output logic                           sw2_pair_cross,
  output logic                           sw2_side_swap,
  output logic      [`PORT_PINS-1:0]     clamp_en,
  output logic      [`PORT_PINS-1:0]     pull_up,
  output logic      [`PORT_PINS-1:0]     pull_down,
  // Comparator outputs of the port lines
  input  wire logic [`PORT_PINS-1:0]     port_level,
  // Crossbar pins, two-way
  input  wire logic [`XPINS-1:0]         xpin_in,
  output logic      [`XPINS-1:0]         xpin_out,
  output logic      [`XPINS-1:0]         xpin_oe,
  // Core serial channels
  input  wire logic [`SERIAL_CHANS-1:0]  core_serial_channel_rx,
  output logic      [`SERIAL_CHANS-1:0]  core_serial_channel_tx,
  // Low-speed endpoint
  input  wire logic                      ep_tx_active,
  input  wire logic                      ep_tok_valid,
  input  wire logic [3:0]                ep_tok_endp,
  output logic                           ep_tok_accept,
  output logic                           ep_lowspeed_mode,
  output logic                           endpoint_lowspeed_pullup_top,
  output logic                           endpoint_lowspeed_pullup_bottom,
  // Charger detection analog enables
  output logic                           contact_detect_current_source_top,
  output logic                           contact_detect_current_source_bottom,
  output logic                           contact_detect_pulldown_top,
  output logic                           contact_detect_pulldown_bottom,
  output logic      [3:0]                charger_detect_voltage_force,
  output logic      [3:0]                charger_detect_current_sink,
  output logic      [3:0]                charger_detect_read
);

  // Software-visible state
  logic [2:0]                ctrl;
  logic [`XBAR_W-1:0]        xbar;
  logic [`PORT_PINS-1:0]     mon_en;
  logic [`CHG_SW_W-1:0]      chg_sw;
  logic [`STAT_W-1:0]        status;
  logic [`STAT_W-1:0]        irq_en;
  logic                      orient_ok;
  logic                      orient_rev;
  logic [`PORT_PINS-1:0]     level_q;
  typec_mux_pkg::src_t       owner_top;
  typec_mux_pkg::src_t       owner_bot;
  typec_mux_pkg::src_t       owner_side;

  // Write decode
  logic wr_ctrl, wr_route, wr_xbar, wr_mon, wr_pull, wr_chg, wr_clr, wr_irq_en;
  assign wr_ctrl   = reg_wr && (reg_addr == `REG_CTRL);
  assign wr_route  = reg_wr && (reg_addr == `REG_ROUTE);
  assign wr_xbar   = reg_wr && (reg_addr == `REG_XBAR);
  assign wr_mon    = reg_wr && (reg_addr == `REG_MON_EN);
  assign wr_pull   = reg_wr && (reg_addr == `REG_PULL);
  assign wr_chg    = reg_wr && (reg_addr == `REG_CHG_SW);
  assign wr_clr    = reg_wr && (reg_addr == `REG_STAT_CLR);
  assign wr_irq_en = reg_wr && (reg_addr == `REG_IRQ_EN);

  // Destinations each source may legally take
  function automatic logic route_legal(typec_mux_pkg::src_t s, typec_mux_pkg::dest_t d);
    case (s)
      typec_mux_pkg::SRC_NONE:  route_legal = 1'b0;
      typec_mux_pkg::SRC_LSX:   route_legal = (d == typec_mux_pkg::DST_SIDE) || (d == typec_mux_pkg::DST_NONE);
      typec_mux_pkg::SRC_UART0: route_legal = (d == typec_mux_pkg::DST_TOP) || (d == typec_mux_pkg::DST_NONE);
      typec_mux_pkg::SRC_UART1: route_legal = (d == typec_mux_pkg::DST_BOTTOM) || (d == typec_mux_pkg::DST_NONE);
      typec_mux_pkg::SRC_UART2: route_legal = (d == typec_mux_pkg::DST_SIDE) || (d == typec_mux_pkg::DST_NONE);
      default:                  route_legal = (s < typec_mux_pkg::SRC_LSX); // Unused codes refused
    endcase
  endfunction : route_legal

  // Route request decode and occupancy check
  typec_mux_pkg::src_t  rt_src;
  typec_mux_pkg::dest_t rt_dst;
  logic                 rt_busy;
  logic                 rt_accept;
  logic                 rt_reject;
  always_comb begin
    rt_src = typec_mux_pkg::src_t'(reg_wdata[`ROUTE_SRC_LSB +: `ROUTE_SRC_W]);
    rt_dst = typec_mux_pkg::dest_t'(reg_wdata[`ROUTE_DST_LSB +: `ROUTE_DST_W]);
    case (rt_dst)
      typec_mux_pkg::DST_TOP:    rt_busy = (owner_top != typec_mux_pkg::SRC_NONE) && (owner_top != rt_src);
      typec_mux_pkg::DST_BOTTOM: rt_busy = (owner_bot != typec_mux_pkg::SRC_NONE) && (owner_bot != rt_src);
      typec_mux_pkg::DST_SIDE:   rt_busy = (owner_side != typec_mux_pkg::SRC_NONE) && (owner_side != rt_src);
      default:                   rt_busy = 1'b0;
    endcase
    rt_accept = wr_route && route_legal(rt_src, rt_dst) && !rt_busy;
    rt_reject = wr_route && !rt_accept;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      owner_top  <= typec_mux_pkg::SRC_NONE;
      owner_bot  <= typec_mux_pkg::SRC_NONE;
      owner_side <= typec_mux_pkg::SRC_NONE;
    end else if (rt_accept) begin
      // Release the source's old slot first, so a move never leaves it on two pairs
      if (owner_top == rt_src) owner_top <= typec_mux_pkg::SRC_NONE;
      if (owner_bot == rt_src) owner_bot <= typec_mux_pkg::SRC_NONE;
      if (owner_side == rt_src) owner_side <= typec_mux_pkg::SRC_NONE;
      if (rt_dst == typec_mux_pkg::DST_TOP) owner_top <= rt_src;
      if (rt_dst == typec_mux_pkg::DST_BOTTOM) owner_bot <= rt_src;
      if (rt_dst == typec_mux_pkg::DST_SIDE) owner_side <= rt_src;
    end
  end

  // Orientation capture; dependent outputs read only these two flops, except the STAT_ORIENT event, which also compares the raw inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_ok  <= 1'b0;
      orient_rev <= 1'b0;
    end else begin
      orient_ok  <= orient_valid;
      orient_rev <= orient_flip;
    end
  end

  // Second-stage closure per physical pin, with orientation applied
  logic top_on, bot_on, side_on;
  logic [`PORT_PINS-1:0] next_close;
  always_comb begin
    top_on  = (owner_top != typec_mux_pkg::SRC_NONE);
    bot_on  = (owner_bot != typec_mux_pkg::SRC_NONE);
    side_on = (owner_side != typec_mux_pkg::SRC_NONE);
    next_close = '0;
    if (orient_ok) begin
      next_close[`PIN_SB_A] = side_on;
      next_close[`PIN_SB_B] = side_on;
      // Whole pairs move together; D+ and D- never trade places
      next_close[`PIN_TOP_DP] = orient_rev ? bot_on : top_on;
      next_close[`PIN_TOP_DM] = orient_rev ? bot_on : top_on;
      next_close[`PIN_BOT_DP] = orient_rev ? top_on : bot_on;
      next_close[`PIN_BOT_DM] = orient_rev ? top_on : bot_on;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw2_close      <= '0;
      clamp_en       <= '0;
      sw2_pair_cross <= 1'b0;
      sw2_side_swap  <= 1'b0;
      dst_top_src    <= typec_mux_pkg::SRC_NONE;
      dst_bottom_src <= typec_mux_pkg::SRC_NONE;
      dst_side_src   <= typec_mux_pkg::SRC_NONE;
    end else begin
      sw2_close      <= next_close;
      clamp_en       <= next_close;
      sw2_pair_cross <= orient_ok && orient_rev;
      sw2_side_swap  <= orient_ok && orient_rev;
      dst_top_src    <= owner_top;
      dst_bottom_src <= owner_bot;
      dst_side_src   <= owner_side;
    end
  end

  // Control registers written by firmware
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= `CTRL_RST;
      xbar      <= `XBAR_RST;
      mon_en    <= '0;
      pull_up   <= '0;
      pull_down <= '0;
      chg_sw    <= '0;
      irq_en    <= '0;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata[2:0];
      if (wr_xbar) xbar <= reg_wdata[`XBAR_W-1:0];
      if (wr_mon) mon_en <= reg_wdata[`PORT_PINS-1:0];
      if (wr_pull) begin
        pull_up   <= reg_wdata[`PULL_UP_LSB +: `PORT_PINS];
        pull_down <= reg_wdata[`PULL_DN_LSB +: `PORT_PINS];
      end
      if (wr_chg) chg_sw <= reg_wdata[`CHG_SW_W-1:0];
      if (wr_irq_en) irq_en <= reg_wdata[`STAT_W-1:0];
    end
  end

  assign charger_detect_voltage_force = chg_sw[`CHG_FORCE_LSB +: 4];
  assign charger_detect_current_sink  = chg_sw[`CHG_SINK_LSB +: 4];
  assign charger_detect_read          = chg_sw[`CHG_READ_LSB +: 4];

  // Crossbar: input pins feed channel tx, output pins take channel rx
  logic [`SERIAL_CHANS-1:0] next_chan_tx;
  logic [`XPINS-1:0]        next_xout;
  logic [`XPINS-1:0]        next_xoe;
  logic [`XCFG_W-1:0]       cfg;
  always_comb begin
    next_chan_tx = '0;
    next_xout    = '0;
    next_xoe     = '0;
    cfg          = '0;
    for (int p = 0; p < `XPINS; p++) begin
      cfg = xbar[p*`XCFG_W +: `XCFG_W];
      if (cfg[2:1] != `XCH_NONE) begin
        if (cfg[`XCFG_DIR_OUT]) begin
          next_xoe[p]  = 1'b1;
          next_xout[p] = core_serial_channel_rx[cfg[2:1]];
        end else begin
          next_chan_tx[cfg[2:1]] = next_chan_tx[cfg[2:1]] | xpin_in[p];
        end
      end
    end
    // daisy-chain bypass wins until firmware clears it
    if (ctrl[`CTRL_BYPASS]) begin
      next_xoe[`XPIN_SYS_TX]  = 1'b1;
      next_xout[`XPIN_SYS_TX] = xpin_in[`XPIN_SYS_RX];
    end
  end

  // Registered crossbar outputs; adds one cycle of latency on each serial path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xpin_out               <= '0;
      xpin_oe                <= '0;
      core_serial_channel_tx <= '0;
    end else begin
      xpin_out               <= next_xout;
      xpin_oe                <= next_xoe;
      core_serial_channel_tx <= next_chan_tx;
    end
  end

  // Endpoint and contact detect analog enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_lowspeed_mode                     <= 1'b1;
      ep_tok_accept                        <= 1'b0;
      endpoint_lowspeed_pullup_top         <= 1'b0;
      endpoint_lowspeed_pullup_bottom      <= 1'b0;
      contact_detect_current_source_top    <= 1'b0;
      contact_detect_current_source_bottom <= 1'b0;
      contact_detect_pulldown_top          <= 1'b0;
      contact_detect_pulldown_bottom       <= 1'b0;
    end else begin
      ep_lowspeed_mode <= 1'b1;
      ep_tok_accept    <= ep_tok_valid && (ep_tok_endp == `EP_CTRL_NUM);
      endpoint_lowspeed_pullup_top    <= ctrl[`CTRL_EP_EN] && orient_ok && !orient_rev && !ep_tx_active;
      endpoint_lowspeed_pullup_bottom <= ctrl[`CTRL_EP_EN] && orient_ok && orient_rev && !ep_tx_active;
      contact_detect_current_source_top    <= ctrl[`CTRL_DCD_EN] && orient_ok && !orient_rev;
      contact_detect_current_source_bottom <= ctrl[`CTRL_DCD_EN] && orient_ok && orient_rev;
      contact_detect_pulldown_top          <= ctrl[`CTRL_DCD_EN] && orient_ok && !orient_rev;
      contact_detect_pulldown_bottom       <= ctrl[`CTRL_DCD_EN] && orient_ok && orient_rev;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  logic [`STAT_W-1:0] events;
  logic [`STAT_W-1:0] next_status;
  always_comb begin
    events = '0;
    events[`PORT_PINS-1:0] = mon_en & (port_level ^ level_q);
    events[`STAT_CONFLICT] = rt_reject;
    events[`STAT_ORIENT]   = (orient_valid != orient_ok) || (orient_valid && (orient_flip != orient_rev));
    next_status = (status & ~(wr_clr ? reg_wdata[`STAT_W-1:0] : '0)) | events;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= '0;
      status  <= '0;
      irq     <= 1'b0;
    end else begin
      level_q <= port_level;
      status  <= next_status;
      irq     <= |(next_status & irq_en);
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL:   reg_rdata <= {29'h0, ctrl};
          `REG_ROUTE:  reg_rdata <= {20'h0, owner_side, owner_bot, owner_top};
          `REG_XBAR:   reg_rdata <= {14'h0, xbar};
          `REG_MON_EN: reg_rdata <= {26'h0, mon_en};
          `REG_PULL:   reg_rdata <= {18'h0, pull_down, 2'h0, pull_up};
          `REG_CHG_SW: reg_rdata <= {20'h0, chg_sw};
          `REG_STATUS: reg_rdata <= {24'h0, status};
          `REG_IRQ_EN: reg_rdata <= {24'h0, irq_en};
          `REG_ORIENT: reg_rdata <= {30'h0, orient_rev, orient_ok};
          default:     reg_rdata <= '0;
        endcase
      end
    end
  end

  // Checks
  property p_pair_cross;
    @(posedge clk) disable iff (!rst_n)
      orient_ok && orient_rev && owner_top != typec_mux_pkg::SRC_NONE |=> sw2_close[`PIN_BOT_DP] && sw2_close[`PIN_BOT_DM];
  endproperty
  a_pair_cross: assert property (p_pair_cross) else $error("top source not moved to bottom pins");
  property p_pair_whole;
    @(posedge clk) disable iff (!rst_n)
      sw2_close[`PIN_TOP_DP] == sw2_close[`PIN_TOP_DM] && sw2_close[`PIN_BOT_DP] == sw2_close[`PIN_BOT_DM];
  endproperty
  a_pair_whole: assert property (p_pair_whole) else $error("pair lines switched apart");
  property p_side_swap;
    @(posedge clk) disable iff (!rst_n) orient_ok |=> sw2_side_swap == $past(orient_rev);
  endproperty
  a_side_swap: assert property (p_side_swap) else $error("sideband swap wrong");
  property p_lsx_side;
    @(posedge clk) disable iff (!rst_n)
      wr_route && rt_src == typec_mux_pkg::SRC_LSX && rt_dst == typec_mux_pkg::DST_TOP |=> owner_top != typec_mux_pkg::SRC_LSX;
  endproperty
  a_lsx_side: assert property (p_lsx_side) else $error("lowspeed transfer reached top pair");
  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      ctrl[`CTRL_BYPASS] |=> xpin_oe[`XPIN_SYS_TX] && xpin_out[`XPIN_SYS_TX] == $past(xpin_in[`XPIN_SYS_RX]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not driven");
  property p_edge;
    @(posedge clk) disable iff (!rst_n) mon_en[`PIN_SB_A] && port_level[`PIN_SB_A] != level_q[`PIN_SB_A] |=> status[`PIN_SB_A];
  endproperty
  a_edge: assert property (p_edge) else $error("edge event lost");
  property p_clamp;
    @(posedge clk) disable iff (!rst_n) clamp_en == sw2_close;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not tied to path");
  property p_tx_pullup;
    @(posedge clk) disable iff (!rst_n)
      ep_tx_active |=> !endpoint_lowspeed_pullup_top && !endpoint_lowspeed_pullup_bottom;
  endproperty
  a_tx_pullup: assert property (p_tx_pullup) else $error("pull-up on during transmit");
  property p_open_invalid;
    @(posedge clk) disable iff (!rst_n) !orient_ok |=> sw2_close == '0;
  endproperty
  a_open_invalid: assert property (p_open_invalid) else $error("path closed without orientation");
  property p_conflict;
    @(posedge clk) disable iff (!rst_n) wr_route && rt_busy |=> status[`STAT_CONFLICT] && $stable(owner_top);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflicting route not refused");
  c_reverse: cover property (@(posedge clk) disable iff (!rst_n) sw2_side_swap && sw2_close[`PIN_SB_A]);
  c_conflict: cover property (@(posedge clk) disable iff (!rst_n) rt_reject);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);

endmodule : typec_port_mux_ctrl

// File: shared/typec_mux_pkg.sv
// Types shared by the port data mux control: route sources and destinations.
// Assumes the register header supplies all offsets and field positions.
package typec_mux_pkg;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_ROOT, SRC_ENDPOINT, SRC_DBGWIRE, SRC_DEBUG12, SRC_DEBUG34,
    SRC_AUX, SRC_LSX, SRC_UART0, SRC_UART1, SRC_UART2
  } src_t;
  typedef enum logic [1:0] {DST_NONE, DST_TOP, DST_BOTTOM, DST_SIDE} dest_t;
endpackage : typec_mux_pkg

// File: shared/typec_mux_regs.svh
// Register offsets, field positions and reset values of the port data mux control.
// Assumes a word-addressed plain register port with 8-bit byte addresses.
`ifndef TYPEC_MUX_REGS_SVH
`define TYPEC_MUX_REGS_SVH

`define MUX_ADDR_W        8
`define MUX_DATA_W        32
// Register byte addresses
`define REG_CTRL          8'h00
`define REG_ROUTE         8'h04
`define REG_XBAR          8'h08
`define REG_MON_EN        8'h0c
`define REG_PULL          8'h10
`define REG_CHG_SW        8'h14
`define REG_STATUS        8'h18
`define REG_STAT_CLR      8'h1c
`define REG_IRQ_EN        8'h20
`define REG_ORIENT        8'h24
// Control fields
`define CTRL_BYPASS       0
`define CTRL_EP_EN        1
`define CTRL_DCD_EN       2
`define CTRL_RST          3'h1
// Route write fields: source code and destination code
`define ROUTE_SRC_LSB     0
`define ROUTE_SRC_W       4
`define ROUTE_DST_LSB     4
`define ROUTE_DST_W       2
// Port pin indices: top D+, top D-, bottom D+, bottom D-, sideband a, sideband b
`define PORT_PINS         6
`define PIN_TOP_DP        0
`define PIN_TOP_DM        1
`define PIN_BOT_DP        2
`define PIN_BOT_DM        3
`define PIN_SB_A          4
`define PIN_SB_B          5
// Crossbar pins: system rx, system tx, lowspeed p2r, lowspeed r2p, general 0, general 1
`define XPINS             6
`define XPIN_SYS_RX       0
`define XPIN_SYS_TX       1
`define XCFG_W            3
`define XCFG_DIR_OUT      0
`define XCH_NONE          2'h3
`define XBAR_W            18
`define XBAR_RST          18'h36db6
`define SERIAL_CHANS      3
// Pull register fields
`define PULL_UP_LSB       0
`define PULL_DN_LSB       8
// Charger detection switches: 4 force, 4 sink, 4 read
`define CHG_SW_W          12
`define CHG_FORCE_LSB     0
`define CHG_SINK_LSB      4
`define CHG_READ_LSB      8
// Status bits
`define STAT_W            8
`define STAT_CONFLICT     6
`define STAT_ORIENT       7
// Endpoint number served
`define EP_CTRL_NUM       4'h0

`endif

// File: testbench/cable_partner.sv
// Cable partner model: reports plug orientation and switches port line levels.
// Assumes the bench asks for attach, flip and per-line toggles.
`timescale 1ns/1ns
module cable_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Requests from the bench
  input  wire logic       attach,
  input  wire logic       flip,
  input  wire logic [5:0] wiggle,
  // Toward the mux control
  output logic            orient_valid,
  output logic            orient_flip,
  output logic      [5:0] port_level
);
  // Detached cable reports upright, so flip never leaks out early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_valid <= 1'b0;
      orient_flip  <= 1'b0;
    end else begin
      orient_valid <= attach;
      orient_flip  <= attach & flip;
    end
  end
  // Line levels switch where a toggle is asked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) port_level <= 6'h00;
    else port_level <= port_level ^ wiggle;
  end
endmodule : cable_partner

// File: testbench/tb_top.sv
// Self-checking bench of the port data mux control with a cable partner.
// Assumes register port timing of one-cycle strobes and next-cycle read data.
`timescale 1ns/1ns
`include "typec_mux_regs.svh"
module tb_top;
  logic clk = 1'b0, rst_n, reg_wr, reg_rd, irq, attach, flip, ep_tx_active, ep_tok_valid, ep_tok_accept;
  logic ep_lowspeed_mode, sw2_pair_cross, sw2_side_swap, orient_valid, orient_flip;
  logic endpoint_lowspeed_pullup_top, endpoint_lowspeed_pullup_bottom;
  logic contact_detect_current_source_top, contact_detect_current_source_bottom;
  logic contact_detect_pulldown_top, contact_detect_pulldown_bottom;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv, r;
  logic [5:0] sw2_close, clamp_en, pull_up, pull_down, port_level, xpin_in, xpin_out, xpin_oe, wiggle;
  logic [2:0] core_serial_channel_rx, core_serial_channel_tx;
  logic [3:0] ep_tok_endp, charger_detect_voltage_force, charger_detect_current_sink, charger_detect_read;
  logic [5:0] bad [4] = '{6'h12, 6'h17, 6'h28, 6'h10};
  typec_mux_pkg::src_t dst_top_src, dst_bottom_src, dst_side_src;
  int n_mismatch = 0;
  int comparisons = 0;
  typec_port_mux_ctrl u_dut (.*);
  cable_partner u_cable (.*);
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Only the control endpoint is answered
  function automatic logic exp_tok(logic [3:0] endp);
    return endp == 4'h0;
  endfunction : exp_tok
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask : rd
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Watchdog well beyond the roughly 150 cycles of the run
  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, attach, flip, wiggle, xpin_in} = '0;
    {core_serial_channel_rx, ep_tx_active, ep_tok_valid, ep_tok_endp, rst_n} = '0;
    void'($urandom(32'h9c52a912));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    chk("sys_tx_oe", xpin_oe[1], 1);
    rd(`REG_XBAR);
    chk("xbar_rst", rdv, `XBAR_RST);
    xpin_in <= 6'h01;
    wt(2);
    chk("bypass", xpin_out[1], 1);
    wr(`REG_ROUTE, 32'h11);
    wt(3);
    chk("sw2_idle", sw2_close, 0);
    attach <= 1'b1;
    wt(4);
    chk("top_src", dst_top_src, typec_mux_pkg::SRC_ROOT);
    chk("sw2_up", {clamp_en, sw2_close}, 12'h0c3);
    flip <= 1'b1;
    wt(4);
    chk("sw2_rev", {sw2_pair_cross, sw2_side_swap, sw2_close}, 8'hcc);
    chk("clamp_rev", clamp_en, 6'h0c);
    // Occupied and illegal routes are all refused
    wr(`REG_IRQ_EN, 32'h40);
    foreach (bad[i]) begin
      wr(`REG_ROUTE, {26'h0, bad[i]});
      wt(2);
      chk("irq_ref", irq, 1);
      rd(`REG_ROUTE);
      chk("route_keep", rdv, 32'h001);
      wr(`REG_STAT_CLR, 32'h40);
    end
    wr(`REG_ROUTE, 32'h37);
    wr(`REG_ROUTE, 32'h29);
    rd(`REG_ROUTE);
    chk("route_ok", {irq, rdv[11:0]}, 13'h0791);
    chk("route_out", {dst_side_src, dst_bottom_src, sw2_close}, {4'h7, 4'h9, 6'h3f});
    repeat (4) begin
      r = $urandom;
      wr(`REG_PULL, r);
      wr(`REG_CHG_SW, r);
      wt(2);
      chk("pull", {pull_down, pull_up}, {r[13:8], r[5:0]});
      chk("chg", {charger_detect_read, charger_detect_current_sink, charger_detect_voltage_force}, r[11:0]);
    end
    wr(`REG_STAT_CLR, 32'hff);
    wr(`REG_IRQ_EN, 32'h10);
    wr(`REG_MON_EN, 32'h30);
    wiggle <= 6'h11;
    @(posedge clk);
    wiggle <= 6'h00;
    wt(2);
    rd(`REG_STATUS);
    chk("edges", {irq, rdv[5:0]}, 7'h50);
    wr(`REG_STAT_CLR, 32'h10);
    wt(2);
    chk("irq_clr", irq, 0);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_XBAR, 32'h11db6);
    core_serial_channel_rx <= 3'h1;
    xpin_in <= 6'h20;
    wt(3);
    chk("xbar", {xpin_oe[4], xpin_out[4], xpin_oe[1], core_serial_channel_tx[1]}, 4'hd);
    wr(`REG_CTRL, 32'h6);
    wt(3);
    chk("ep_pu", {endpoint_lowspeed_pullup_top, endpoint_lowspeed_pullup_bottom}, 2'b01);
    chk("dcd", {contact_detect_current_source_top, contact_detect_current_source_bottom,
                contact_detect_pulldown_top, contact_detect_pulldown_bottom}, 4'b0101);
    ep_tx_active <= 1'b1;
    wt(3);
    chk("ep_tx_pu", endpoint_lowspeed_pullup_bottom, 0);
    for (int i = 0; i < 6; i++) begin
      ep_tok_valid <= 1'b1;
      ep_tok_endp  <= (i == 0) ? 4'h0 : 4'($urandom);
      @(posedge clk);
      ep_tok_valid <= 1'b0;
      #1;
      chk("tok", {ep_lowspeed_mode, ep_tok_accept}, {1'b1, exp_tok(ep_tok_endp)});
      @(posedge clk);
    end
    give_verdict();
  end
endmodule : tb_top
